// *** hdl/serial_pause_dev.sv ***
`timescale 1ns/100ps
`include "serial_pause_params.svh"
module serial_pause_dev
  import serial_pause_pkg::*;
#(
  parameter int WORD_BITS = `SP_WORD_BITS
)
(
  input wire logic mclk,
  input wire logic resetn,
  serial_pause_if.dev lnk,
  input wire logic [WORD_BITS-1:0] tx_word,
  output logic [WORD_BITS-1:0] rx_word,
  output logic rx_valid,
  output logic tx_taken,
  output logic paused,
  output logic selected
);
  initial
  begin
    if (WORD_BITS < 2 || WORD_BITS > 64)
      $error("WORD_BITS out of range");
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [3:0] meta_r;
  logic [3:0] sync_r;
  logic sclk_d_r;
  // Two stages before any logic looks at a pin
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      // Idle pin levels: clock low, select high, pause high, so no false edge
      meta_r <= 4'h6;
      sync_r <= 4'h6;
      sclk_d_r <= 1'b0;
    end
    else
    begin
      meta_r <= {lnk.sdi, lnk.pause_n, lnk.sel_n, lnk.sclk};
      sync_r <= meta_r;
      sclk_d_r <= sync_r[0];
    end
  end

  wire s_sclk = sync_r[0];
  wire s_sel_n = sync_r[1];
  wire s_pause_n = sync_r[2];
  wire s_sdi = sync_r[3];
  wire rise = s_sclk & ~sclk_d_r;
  wire fall = ~s_sclk & sclk_d_r;

  // ------------------------------------------------------------
  // Pause qualification
  // ------------------------------------------------------------
  logic hold_r;
  logic busy_r;
  // Enter with clock low, else wait for the next low; leave while low, or at once on deselect
  wire hold_nxt = s_sel_n ? 1'b0 :
                  (!hold_r && !s_pause_n && busy_r && !s_sclk) ? 1'b1 :
                  (hold_r && s_pause_n && !s_sclk) ? 1'b0 :
                  hold_r;
  // Shifting is gated off whole while paused, so edges are ignored
  wire act = !s_sel_n && !hold_r;

  // ------------------------------------------------------------
  // Shift datapath
  // ------------------------------------------------------------
  localparam int CW = $clog2(WORD_BITS);
  logic [CW-1:0] cnt_r;
  logic [WORD_BITS-1:0] rsh_r;
  logic [WORD_BITS-1:0] tsh_r;
  logic sdo_r;
  logic oe_r;
  wire last = (cnt_r == CW'(WORD_BITS - 1));
  wire [WORD_BITS-1:0] rsh_nxt = {rsh_r[WORD_BITS-2:0], s_sdi};
  // Output floats at once on pause low, hold or deselect
  wire oe_nxt = !s_sel_n && s_pause_n && !hold_nxt;

  // Counter and capture run on rising edges only
  always_ff @(posedge mclk)
  begin
    if (!resetn || s_sel_n)
    begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      rx_valid <= 1'b0;
      rsh_r <= '0;
    end
    else
    begin
      rx_valid <= 1'b0;
      if (act && rise)
      begin
        rsh_r <= rsh_nxt;
        busy_r <= 1'b1;
        cnt_r <= last ? '0 : cnt_r + 1'b1;
        rx_valid <= last;
      end
    end
  end

  // Received word held until the next one
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      rx_word <= '0;
    else if (!s_sel_n && act && rise && last)
      rx_word <= rsh_nxt;
  end

  // Output shifter advances after falling edges; a word reloads at count zero
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      tsh_r <= '0;
      sdo_r <= 1'b1;
      tx_taken <= 1'b0;
      hold_r <= 1'b0;
    end
    else if (s_sel_n)
    begin
      // First bit must stand before the first rising edge; output is floated here
      sdo_r <= tx_word[WORD_BITS-1];
      tsh_r <= {tx_word[WORD_BITS-2:0], 1'b0};
      tx_taken <= 1'b0;
      hold_r <= 1'b0;
    end
    else
    begin
      hold_r <= hold_nxt;
      tx_taken <= 1'b0;
      if (act && fall)
      begin
        if (cnt_r == '0)
        begin
          sdo_r <= tx_word[WORD_BITS-1];
          tsh_r <= {tx_word[WORD_BITS-2:0], 1'b0};
          tx_taken <= 1'b1;
        end
        else
        begin
          sdo_r <= tsh_r[WORD_BITS-1];
          tsh_r <= {tsh_r[WORD_BITS-2:0], 1'b0};
        end
      end
    end
  end

  // Status and enables registered for the pins
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      oe_r <= 1'b0;
      paused <= 1'b0;
      selected <= 1'b0;
      lnk.sclk_in_en <= 1'b0;
    end
    else
    begin
      oe_r <= oe_nxt;
      paused <= hold_nxt;
      selected <= !s_sel_n;
      lnk.sclk_in_en <= !s_sel_n && !hold_nxt;
    end
  end

  assign lnk.sdo = sdo_r;
  assign lnk.sdo_oe = oe_r;
endmodule

// *** hdl/serial_pause_params.svh ***
`ifndef SERIAL_PAUSE_PARAMS_SVH
`define SERIAL_PAUSE_PARAMS_SVH
// Default bit width of one shifted unit
`define SP_WORD_BITS 8
// Default link clock divider (half period in mclk cycles)
`define SP_HALF_DIV 10
// Default idle reply byte of the device end
`define SP_IDLE_BYTE 8'hff
`endif

// *** hdl/serial_pause_pkg.sv ***
package serial_pause_pkg;
  // Master sequencer states
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_PAUSE = 2'b10,
    ST_DONE = 2'b11
  } mst_state_t;
endpackage

// *** hdl/serial_pause_if.sv ***
`timescale 1ns/100ps
// Link between the serial master and the paused slave end
interface serial_pause_if;
  logic sclk;
  logic sel_n;
  logic sdi;
  logic pause_n;
  logic sdo;
  logic sdo_oe;
  // Slave pins float while paused; the bench only checks the enables, nothing resolves the pins
  logic sclk_in_en;
  modport dev
  (
    input sclk,
    input sel_n,
    input sdi,
    input pause_n,
    output sdo,
    output sdo_oe,
    output sclk_in_en
  );
  modport mst
  (
    output sclk,
    output sel_n,
    output sdi,
    output pause_n,
    input sdo,
    input sdo_oe,
    input sclk_in_en
  );
endinterface

// *** hdl/serial_pause_mst.sv ***
`timescale 1ns/100ps
`include "serial_pause_params.svh"
module serial_pause_mst
  import serial_pause_pkg::*;
#(
  parameter int WORD_BITS = `SP_WORD_BITS,
  parameter int HALF_DIV = `SP_HALF_DIV
)
(
  input wire logic mclk,
  input wire logic resetn,
  serial_pause_if.mst lnk,
  input wire logic start,
  input wire logic stop,
  input wire logic pause_req,
  input wire logic [WORD_BITS-1:0] tx_word,
  output logic [WORD_BITS-1:0] rx_word,
  output logic rx_valid,
  output logic busy
);
  initial
  begin
    if (HALF_DIV < 2 || WORD_BITS < 2)
      $error("Bad master parameters");
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  mst_state_t st_r;
  mst_state_t st_nxt;
  logic [15:0] div_r;
  logic sclk_r;
  logic sel_n_r;
  logic pause_n_r;
  logic sdi_r;
  logic [7:0] bit_r;
  logic [WORD_BITS-1:0] tsh_r;
  logic [WORD_BITS-1:0] rsh_r;
  logic [1:0] sdo_s_r;
  wire tick = (div_r == 16'(HALF_DIV - 1));
  wire edge_up = tick && !sclk_r;
  wire edge_dn = tick && sclk_r;

  // Pause changes only with clock low, so the slave never defers
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: if (start) st_nxt = ST_RUN;
      ST_RUN: if (pause_req && !sclk_r) st_nxt = ST_PAUSE;
        else if (stop && !sclk_r && bit_r == 8'h00) st_nxt = ST_DONE;
      ST_PAUSE: if (!pause_req) st_nxt = ST_RUN;
      ST_DONE: st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      st_r <= ST_IDLE;
      div_r <= '0;
      sclk_r <= 1'b0;
      sel_n_r <= 1'b1;
      pause_n_r <= 1'b1;
      sdi_r <= 1'b0;
      bit_r <= '0;
      tsh_r <= '0;
      rsh_r <= '0;
      rx_word <= '0;
      rx_valid <= 1'b0;
      sdo_s_r <= 2'b00;
      busy <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      sdo_s_r <= {sdo_s_r[0], lnk.sdo};
      rx_valid <= 1'b0;
      busy <= (st_nxt != ST_IDLE);
      pause_n_r <= (st_nxt != ST_PAUSE);
      sel_n_r <= (st_nxt == ST_IDLE) || (st_nxt == ST_DONE);
      if (st_r == ST_IDLE && start)
      begin
        tsh_r <= {tx_word[WORD_BITS-2:0], 1'b0};
        sdi_r <= tx_word[WORD_BITS-1];
        bit_r <= '0;
        div_r <= '0;
      end
      else if (st_r == ST_RUN && st_nxt == ST_RUN)
      begin
        div_r <= tick ? '0 : div_r + 16'h1;
        if (tick)
          sclk_r <= !sclk_r;
        if (edge_up)
        begin
          rsh_r <= {rsh_r[WORD_BITS-2:0], sdo_s_r[1]};
          if (bit_r == 8'(WORD_BITS - 1))
          begin
            rx_word <= {rsh_r[WORD_BITS-2:0], sdo_s_r[1]};
            rx_valid <= 1'b1;
            bit_r <= '0;
          end
          else
            bit_r <= bit_r + 8'h1;
        end
        if (edge_dn)
        begin
          sdi_r <= (bit_r == 8'h00) ? tx_word[WORD_BITS-1] : tsh_r[WORD_BITS-1];
          tsh_r <= (bit_r == 8'h00) ? {tx_word[WORD_BITS-2:0], 1'b0}
                                    : {tsh_r[WORD_BITS-2:0], 1'b0};
        end
      end
      else if (st_r == ST_DONE)
        sclk_r <= 1'b0;
    end
  end

  assign lnk.sclk = sclk_r;
  assign lnk.sel_n = sel_n_r;
  assign lnk.pause_n = pause_n_r;
  assign lnk.sdi = sdi_r;
endmodule

// *** bench/serial_pause_monitor.sv ***
`timescale 1ns/100ps
// ----
// Link checks
// ----
module serial_pause_monitor
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic sdi,
  input wire logic pause_n,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic sclk_in_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Long enough for the sync chain
  sequence s_held;
    !pause_n [*5];
  endsequence
  sequence s_desel;
    sel_n [*5];
  endsequence
  // Pin relations
  a_sdi_rise_stable: assert property ($rose(sclk) && !sel_n |-> $stable(sdi))
    else $error("sdi moved at clock rise");
  a_sdo_low_phase: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo) |-> !sclk)
    else $error("sdo moved in high phase");
  a_idle_pause_high: assert property (sel_n |-> pause_n)
    else $error("pause low while idle");
  a_pause_clock_low: assert property ($fell(pause_n) |-> !sclk)
    else $error("pause dropped with clock high");
  a_hold_keeps_sel: assert property (!pause_n |-> !sel_n)
    else $error("select lost while paused");
  a_hold_floats_in: assert property (s_held |-> !sclk_in_en)
    else $error("inputs live while paused");
  a_resume_clock_low: assert property ($rose(pause_n) && !sel_n |-> !sclk)
    else $error("resume with clock high");
  a_hold_floats_out: assert property (s_held |-> !sdo_oe)
    else $error("sdo driven while paused");
  a_desel_floats: assert property (s_desel |-> !sdo_oe)
    else $error("sdo driven while deselected");
endmodule

// *** bench/test_serial_port_pause_control.sv ***
`timescale 1ns/100ps
// ----
// Bench: master end facing device end
// ----
module test_serial_port_pause_control;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic start = 1'b0;
  logic stop = 1'b1;
  logic pause_req = 1'b0;
  logic [7:0] m_tx = 8'h00;
  logic [7:0] d_tx = 8'h00;
  logic [7:0] m_rx, d_rx;
  logic m_valid, d_valid, busy, paused, selected;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic d_taken;
  int taken_n = 0;
  int dval_n = 0;
  int mval_n = 0;
  // Pulse counters for the one-cycle outputs
  always @(posedge mclk)
  begin
    if (d_taken === 1'b1) taken_n++;
    if (d_valid === 1'b1) dval_n++;
    if (m_valid === 1'b1) mval_n++;
  end
  serial_pause_if lnk();
  // Both ends and the pin checker
  serial_pause_mst serial_pause_mst_inst (.mclk(mclk), .resetn(resetn), .lnk(lnk.mst),
    .start(start), .stop(stop), .pause_req(pause_req), .tx_word(m_tx), .rx_word(m_rx),
    .rx_valid(m_valid), .busy(busy));
  serial_pause_dev serial_pause_dev_inst (.mclk(mclk), .resetn(resetn), .lnk(lnk.dev),
    .tx_word(d_tx), .rx_word(d_rx), .rx_valid(d_valid), .tx_taken(d_taken), .paused(paused),
    .selected(selected));
  serial_pause_monitor serial_pause_monitor_inst (.mclk(mclk), .resetn(resetn),
    .sclk(lnk.sclk), .sel_n(lnk.sel_n), .sdi(lnk.sdi), .pause_n(lnk.pause_n),
    .sdo(lnk.sdo), .sdo_oe(lnk.sdo_oe), .sclk_in_en(lnk.sclk_in_en));
  // Clock and hang guard
  always #2 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      mismatches++;
      results();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // One word each way; optional hold after hold_at cycles
  task automatic xfer(input logic [7:0] mw, input logic [7:0] dw, input int hold_at);
    int i;
    int tk0;
    int dv0;
    int mv0;
    tk0 = taken_n;
    dv0 = dval_n;
    mv0 = mval_n;
    m_tx = mw;
    d_tx = dw;
    start = 1'b1;
    stop = 1'b0;
    tick(1);
    start = 1'b0;
    // Stop is only honoured at a word boundary, so raise it once the word runs
    tick(20);
    stop = 1'b1;
    if (hold_at > 0)
    begin
      tick(hold_at - 20);
      pause_req = 1'b1;
      tick(200);
      check("paused", paused, 1'b1);
      check("sdo_oe", lnk.sdo_oe, 1'b0);
      check("sclk_in_en", lnk.sclk_in_en, 1'b0);
      check("sel_n", lnk.sel_n, 1'b0);
      pause_req = 1'b0;
    end
    tick(4);
    i = 0;
    while (busy !== 1'b0 && i < 4000)
    begin
      tick(1);
      i++;
    end
    tick(8);
    check("dev rx", d_rx, mw);
    check("mst rx", m_rx, dw);
    check("selected", selected, 1'b0);
    check("dev valid n", 8'(dval_n - dv0), 8'h01);
    check("mst valid n", 8'(mval_n - mv0), 8'h01);
    check("taken n", 8'(taken_n - tk0), 8'h01);
  endtask
  task automatic t_idle();
    check("pause_n", lnk.pause_n, 1'b1);
    check("idle sdo_oe", lnk.sdo_oe, 1'b0);
    $display("idle done");
  endtask
  // Back to back, bit order at both ends of the word
  task automatic t_plain();
    xfer(8'ha5, 8'h3c, 0);
    xfer(8'h80, 8'h01, 0);
    $display("plain done");
  endtask
  // Hold early in a word and just after its last bit; a restart would lose bits
  task automatic t_pause();
    xfer(8'h5a, 8'hc3, 45);
    xfer(8'h0f, 8'hf0, 150);
    $display("pause done");
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    tick(16);
    resetn = 1'b1;
    tick(2);
    t_idle();
    t_plain();
    t_pause();
    results();
  end
endmodule
